// ===== verilog/ast_top.sv
// asynchronous serial transceiver with an axi4-lite register slave
// assumes aclk at 10 MHz, rxd from an outside pin, timer3_output a one-cycle pulse on aclk
`timescale 1ns/10ps
`include "ast_map.svh"
module ast_top
	import ast_pkg::*;
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [`AST_ADDR_W-1:0] awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	input  wire logic [`AST_ADDR_W-1:0] araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	input  wire logic                   rxd,
	input  wire logic                   timer3_output,
	output logic                        txd,
	output logic                        tx_start_interrupt,
	output logic                        rx_done_interrupt
);

	function automatic logic maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction : maj3

	// parity bit that completes the byte to the chosen sense
	function automatic logic par_of(input ast_byte_t d, input logic even);
		return even ? ^d : ~^d;
	endfunction : par_of

	function automatic logic [8:0] rate_div(input logic [2:0] code);
		case (code)
			3'h0:    return `AST_DIV_0;
			3'h1:    return `AST_DIV_1;
			3'h2:    return `AST_DIV_2;
			3'h3:    return `AST_DIV_3;
			3'h4:    return `AST_DIV_4;
			3'h5:    return `AST_DIV_5;
			default: return `AST_DIV_7;
		endcase
	endfunction : rate_div

	ast_byte_t             ctrl_r, stat_r, rx_hold_r, tx_hold_r;
	logic [`AST_ADDR_W-1:0] aw_addr_r;
	logic [31:0]           w_data_r;
	logic [3:0]            w_strb_r;
	logic                  aw_got_r, w_got_r, st_rd_r, overrun_fault_flag_seen_r;
	logic [2:0]            rxs_r;
	logic                  rx_fil_r;
	logic                  parity_fault_flag_r, framing_fault_flag_r, overrun_fault_flag_r, rx_holding_full_flag_r, tx_done_flag_r, tx_holding_empty_flag_r;
	logic [8:0]            div_r;
	logic                  tick_r;
	ast_rx_e               rx_st_r;
	logic [3:0]            rx_sub_r, rx_bit_r;
	logic                  smp7_r, smp8_r;
	ast_byte_t             rx_sh_r;
	logic                  rx_par_r;
	logic                  tx_busy_r, tx_pend_r;
	logic [11:0]           tx_sh_r;
	logic [3:0]            tx_sub_r, tx_cnt_r;

	wire logic do_wr   = aw_got_r & w_got_r & ~bvalid;
	wire logic wr_ctrl = do_wr & (aw_addr_r == `AST_OFF_CTRL) & w_strb_r[0];
	wire logic wr_data = do_wr & (aw_addr_r == `AST_OFF_DATA) & w_strb_r[0];
	wire logic rd_go   = arvalid & arready;
	wire logic rd_stat = rd_go & (araddr == `AST_OFF_STAT);
	wire logic rd_data = rd_go & (araddr == `AST_OFF_DATA);
	wire logic rx_in   = rx_fil_r;
	wire logic rx_smp  = tick_r & (rx_st_r == rx_frame) & (rx_sub_r == `AST_SMP_C);
	wire logic rx_maj  = maj3(smp7_r, smp8_r, rx_in);
	wire logic par_on  = ctrl_r[`AST_B_PAR];
	wire logic rx_stop = rx_smp & (rx_bit_r == (par_on ? `AST_RX_PAR + 4'h1 : `AST_RX_PAR));
	wire logic tx_last = tick_r & tx_busy_r & (tx_sub_r == `AST_TICK_LAST) & (tx_cnt_r == 4'h1);
	wire logic tx_load = tx_pend_r & ctrl_r[`AST_B_TXEN] & (~tx_busy_r | tx_last);
	wire logic wr_ok   = wr_data & st_rd_r;

	// status byte gathered from the flag registers, one owner per flag
	assign stat_r = {parity_fault_flag_r, framing_fault_flag_r, overrun_fault_flag_r, rx_holding_full_flag_r, tx_done_flag_r, tx_holding_empty_flag_r, 2'h0};

	// write channel: address and data taken in either order, reply once both held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b0;
			wready    <= 1'b0;
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= '0;
			w_strb_r  <= '0;
			bvalid    <= 1'b0;
			bresp     <= `AST_RESP_OK;
		end else begin
			if (awvalid && awready) begin
				awready   <= 1'b0;
				aw_got_r  <= 1'b1;
				aw_addr_r <= awaddr;
			end else if (!aw_got_r && !bvalid) begin
				awready <= 1'b1;
			end
			if (wvalid && wready) begin
				wready   <= 1'b0;
				w_got_r  <= 1'b1;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end else if (!w_got_r && !bvalid) begin
				wready <= 1'b1;
			end
			if (do_wr) begin
				bvalid   <= 1'b1;
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				// status is read only; unmapped slots answer slverr
				bresp <= (aw_addr_r == `AST_OFF_CTRL || aw_addr_r == `AST_OFF_DATA)
					? `AST_RESP_OK : `AST_RESP_ERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read channel: one outstanding read, data captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= `AST_RESP_OK;
		end else if (rd_go) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= `AST_RESP_OK;
			case (araddr)
				`AST_OFF_CTRL: rdata <= {24'h000000, ctrl_r};
				`AST_OFF_STAT: rdata <= {24'h000000, stat_r};
				`AST_OFF_DATA: rdata <= {24'h000000, rx_hold_r};
				default: begin
					rdata <= '0;
					rresp <= `AST_RESP_ERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	// control register; rate must only change with both directions idle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_r <= `AST_CTRL_RST;
		else if (wr_ctrl)
			ctrl_r <= w_data_r[7:0];
	end

	// status-read arming: a data read or write ends the read-then-access sequence, except a data write in the same cycle as a status read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_rd_r     <= 1'b0;
			overrun_fault_flag_seen_r <= 1'b0;
		end else if (rd_stat) begin
			st_rd_r     <= 1'b1;
			overrun_fault_flag_seen_r <= stat_r[`AST_B_OVERRUN_FAULT_FLAG];
		end else if (rd_data || wr_data) begin
			st_rd_r <= 1'b0;
		end
	end

	// rate tick: divider or timer3 pulse, sixteen per bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else if (ctrl_r[`AST_F_RATE] == `AST_RATE_TMR) begin
			div_r  <= '0;
			tick_r <= timer3_output;
		end else if (div_r >= rate_div(ctrl_r[`AST_F_RATE]) - 9'h001) begin
			div_r  <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r  <= div_r + 9'h001;
			tick_r <= 1'b0;
		end
	end

	// three-stage pin synchroniser, reset to the idle-high line level
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rxs_r <= 3'h7;
		else
			rxs_r <= {rxs_r[1:0], rxd};
	end

	// a change counts once stages two and three agree; the first stage feeds nothing else
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rx_fil_r <= 1'b1;
		else if (rxs_r[2] == rxs_r[1])
			rx_fil_r <= rxs_r[2];
	end

	// receiver sequencer: start detect, majority sampling, frame end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_st_r  <= rx_hunt;
			rx_sub_r <= '0;
			rx_bit_r <= '0;
			smp7_r   <= 1'b1;
			smp8_r   <= 1'b1;
			rx_sh_r  <= '0;
			rx_par_r <= 1'b0;
		end else begin
			case (rx_st_r)
				rx_hunt: begin
					// enable only looked at here, so a disable waits for frame end
					if (tick_r && !rx_in && ctrl_r[`AST_B_RXEN] &&
					    !stat_r[`AST_B_OVERRUN_FAULT_FLAG]) begin
						rx_st_r  <= rx_frame;
						rx_sub_r <= 4'h1;
						rx_bit_r <= '0;
					end
				end
				rx_frame: begin
					if (tick_r) begin
						rx_sub_r <= rx_sub_r + 4'h1;
						if (rx_sub_r == `AST_SMP_A)
							smp7_r <= rx_in;
						if (rx_sub_r == `AST_SMP_B)
							smp8_r <= rx_in;
						if (rx_sub_r == `AST_TICK_LAST)
							rx_bit_r <= rx_bit_r + 4'h1;
					end
					if (rx_smp) begin
						if (rx_bit_r == 4'h0 && rx_maj)
							rx_st_r <= rx_hunt;
						else if (rx_bit_r >= 4'h1 && rx_bit_r <= `AST_RX_LAST_D)
							rx_sh_r <= {rx_maj, rx_sh_r[7:1]};
						else if (rx_bit_r == `AST_RX_PAR && par_on)
							rx_par_r <= rx_maj;
						// finish mid stop bit so the next start edge is not missed
						if (rx_stop)
							rx_st_r <= rx_hunt;
					end
				end
				default: rx_st_r <= rx_hunt;
			endcase
		end
	end

	// receive holding register and its flags; a hardware set beats a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_hold_r         <= '0;
			rx_done_interrupt <= 1'b0;
			parity_fault_flag_r            <= 1'b0;
			framing_fault_flag_r            <= 1'b0;
			overrun_fault_flag_r            <= 1'b0;
			rx_holding_full_flag_r            <= 1'b0;
		end else begin
			rx_done_interrupt <= 1'b0;
			if (rd_data && st_rd_r) begin
				parity_fault_flag_r <= 1'b0;
				framing_fault_flag_r <= 1'b0;
				rx_holding_full_flag_r <= 1'b0;
				if (overrun_fault_flag_seen_r)
					overrun_fault_flag_r <= 1'b0;
			end
			if (rx_stop) begin
				if (!rx_maj)
					framing_fault_flag_r <= 1'b1;
				if (par_on && rx_par_r != par_of(rx_sh_r, ctrl_r[`AST_B_EVEN]))
					parity_fault_flag_r <= 1'b1;
				if (rx_holding_full_flag_r && !(rd_data && st_rd_r)) begin
					overrun_fault_flag_r <= 1'b1;
				end else begin
					rx_hold_r         <= rx_sh_r;
					rx_holding_full_flag_r            <= 1'b1;
					rx_done_interrupt <= 1'b1;
				end
			end
		end
	end

	// transmit holding register, shifter and flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_hold_r          <= '0;
			tx_pend_r          <= 1'b0;
			tx_busy_r          <= 1'b0;
			tx_sh_r            <= '1;
			tx_sub_r           <= '0;
			tx_cnt_r           <= '0;
			txd                <= 1'b1;
			tx_start_interrupt <= 1'b0;
			tx_done_flag_r             <= 1'b1;
			tx_holding_empty_flag_r             <= 1'b1;
		end else begin
			tx_start_interrupt <= 1'b0;
			txd <= tx_busy_r ? tx_sh_r[0] : 1'b1;
			if (tick_r && tx_busy_r) begin
				tx_sub_r <= tx_sub_r + 4'h1;
				if (tx_sub_r == `AST_TICK_LAST) begin
					tx_sh_r  <= {1'b1, tx_sh_r[11:1]};
					tx_cnt_r <= tx_cnt_r - 4'h1;
				end
			end
			if (tx_last) begin
				tx_busy_r <= 1'b0;
				if (tx_holding_empty_flag_r || !ctrl_r[`AST_B_TXEN])
					tx_done_flag_r <= 1'b1;
			end
			if (tx_load) begin
				tx_pend_r <= 1'b0;
				tx_busy_r <= 1'b1;
				tx_sub_r  <= '0;
				tx_cnt_r  <= `AST_TX_BASE + {3'h0, par_on} + {3'h0, ctrl_r[`AST_B_STOP2]};
				tx_sh_r   <= par_on ? {2'h3, par_of(tx_hold_r, ctrl_r[`AST_B_EVEN]),
					tx_hold_r, 1'b0} : {3'h7, tx_hold_r, 1'b0};
				tx_holding_empty_flag_r <= 1'b1;
				tx_done_flag_r <= 1'b0;
				tx_start_interrupt <= 1'b1;
			end
			if (wr_ok) begin
				tx_hold_r <= w_data_r[7:0];
				tx_pend_r <= 1'b1;
				tx_holding_empty_flag_r <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_txd_idle_high: assert property (!tx_busy_r |=> txd)
		else $error("txd low while transmitter idle");
	chk_tx_holding_empty_flag_on_start: assert property (tx_load && !wr_ok |=> stat_r[`AST_B_TX_HOLDING_EMPTY_FLAG] &&
		tx_start_interrupt)
		else $error("shift start did not set empty flag and interrupt");
	chk_unarmed_write: assert property (wr_data && !st_rd_r && stat_r[`AST_B_TX_HOLDING_EMPTY_FLAG]
		|=> stat_r[`AST_B_TX_HOLDING_EMPTY_FLAG] && !tx_pend_r)
		else $error("holding write without status read was taken");
	chk_rx_load_full: assert property (rx_stop && !stat_r[`AST_B_RX_HOLDING_FULL_FLAG] |=>
		stat_r[`AST_B_RX_HOLDING_FULL_FLAG] && rx_done_interrupt && rx_hold_r == $past(rx_sh_r))
		else $error("received byte not loaded");
	chk_overrun_keep: assert property (rx_stop && stat_r[`AST_B_RX_HOLDING_FULL_FLAG] && !rd_data |=>
		stat_r[`AST_B_OVERRUN_FAULT_FLAG] && $stable(rx_hold_r))
		else $error("overrun not flagged or held byte changed");
	chk_overrun_fault_flag_blocks_rx: assert property (stat_r[`AST_B_OVERRUN_FAULT_FLAG] && rx_st_r == rx_hunt
		|=> rx_st_r == rx_hunt)
		else $error("reception started while overrun set");
	chk_framing_fault_flag_stop_low: assert property (rx_stop && !rx_maj |=> stat_r[`AST_B_FRAMING_FAULT_FLAG])
		else $error("low stop bit without framing flag");
	chk_clear_by_read: assert property (rd_data && st_rd_r && !rx_stop |=>
		!stat_r[`AST_B_RX_HOLDING_FULL_FLAG] && !stat_r[`AST_B_PARITY_FAULT_FLAG])
		else $error("status-then-data read did not clear flags");
	chk_tx_done_flag_clear: assert property (tx_load |=> !stat_r[`AST_B_TX_DONE_FLAG] ##1 tx_busy_r)
		else $error("done flag stayed set at transmit start");
	chk_rx_false_start: assert property (rx_smp && rx_bit_r == 4'h0 && rx_maj
		|=> rx_st_r == rx_hunt)
		else $error("false start not rejected");

	cov_tx_frame: cover property (tx_load ##[1:300] tx_last);
	cov_rx_frame: cover property (rx_stop && !stat_r[`AST_B_RX_HOLDING_FULL_FLAG]);
	cov_overrun:  cover property (rx_stop && stat_r[`AST_B_RX_HOLDING_FULL_FLAG]);
	cov_back2back: cover property (tx_last && tx_load);

endmodule : ast_top

// ===== verilog/ast_map.svh
// register map, field positions, reset values and divider counts
// assumes inclusion by the transceiver top module
`ifndef AST_MAP_SVH
`define AST_MAP_SVH

`define AST_ADDR_W     4
`define AST_OFF_CTRL   4'h0
`define AST_OFF_STAT   4'h4
`define AST_OFF_DATA   4'h8

`define AST_B_TXEN     7
`define AST_B_RXEN     6
`define AST_B_STOP2    5
`define AST_B_EVEN     4
`define AST_B_PAR      3
`define AST_F_RATE     2:0

`define AST_B_PARITY_FAULT_FLAG     7
`define AST_B_FRAMING_FAULT_FLAG     6
`define AST_B_OVERRUN_FAULT_FLAG     5
`define AST_B_RX_HOLDING_FULL_FLAG     4
`define AST_B_TX_DONE_FLAG     3
`define AST_B_TX_HOLDING_EMPTY_FLAG     2

`define AST_CTRL_RST   8'h00
`define AST_STAT_RST   8'h0c

`define AST_RATE_TMR   3'h6
`define AST_DIV_0      9'h00d
`define AST_DIV_1      9'h01a
`define AST_DIV_2      9'h034
`define AST_DIV_3      9'h068
`define AST_DIV_4      9'h0d0
`define AST_DIV_5      9'h1a0
`define AST_DIV_7      9'h060

`define AST_TICK_LAST  4'hf
`define AST_SMP_A      4'h7
`define AST_SMP_B      4'h8
`define AST_SMP_C      4'h9
`define AST_RX_LAST_D  4'h8
`define AST_RX_PAR     4'h9
`define AST_TX_BASE    4'ha

`define AST_RESP_OK    2'h0
`define AST_RESP_ERR   2'h2

`endif

// ===== verilog/ast_pkg.sv
// shared types of the asynchronous serial transceiver
// assumes ast_map.svh sits in the include path
package ast_pkg;
	typedef enum logic {rx_hunt, rx_frame} ast_rx_e;
	typedef logic [7:0] ast_byte_t;
endpackage : ast_pkg

// ===== sim/ast_remote.sv
// far-end serial transceiver: frames bytes onto rxd, decodes txd into queues
// assumes one bit spans 208 aclk cycles: rate code 0, or code 6 on a 13-cycle timer pulse
`timescale 1ns/10ps
module ast_remote #(
	parameter int BIT = 208
) (
	input  wire logic aclk,
	input  wire logic txd,
	output logic      rxd
);
	logic       par_on = 1'b0;
	logic       even   = 1'b0;
	logic [7:0] byte_q[$];
	logic       par_q[$];
	longint     t_q[$];

	// line is pulled high while nothing is sent
	initial rxd = 1'b1;

	task automatic hold(input int n);
		repeat (n) @(posedge aclk);
	endtask : hold

	// a bad stop is low for about twelve ticks, so its tail looks like a false start
	task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
		rxd <= 1'b0;
		hold(BIT);
		for (int i = 0; i < 8; i++) begin
			rxd <= b[i];
			hold(BIT);
		end
		if (par_on) begin
			rxd <= (even ? ^b : ~^b) ^ bad_par;
			hold(BIT);
		end
		rxd <= ~bad_stop;
		if (bad_stop) begin
			hold(160);
			rxd <= 1'b1;
		end
		hold(3 * BIT);
	endtask : send

	// decoder samples each data and parity bit at its middle; start time kept for gap checks
	always begin
		logic [7:0] b;
		logic       p;
		longint     t;
		@(negedge txd);
		t = $time;
		p = 1'b0;
		hold(BIT / 2);
		for (int i = 0; i < 8; i++) begin
			hold(BIT);
			b[i] = txd;
		end
		if (par_on) begin
			hold(BIT);
			p = txd;
		end
		hold(BIT);
		byte_q.push_back(b);
		par_q.push_back(p);
		t_q.push_back(t);
	end
endmodule : ast_remote

// ===== sim/tb.sv
// self-checking bench for the serial transceiver over axi4-lite
// assumes 208-cycle bits (code 0, or code 6 on the bench timer pulse) and the remote model
`timescale 1ns/10ps
module tb;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  awaddr = 4'h0;
	logic [3:0]  araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, rxd, txd, txi, rxi;
	logic        tmr3 = 1'b0;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, v, seed = 32'd73469;
	logic [7:0]  d0, d1, cfg[3] = '{8'h80, 8'hb8, 8'h88};
	logic [3:0]  rxc[4] = '{4'b0000, 4'b1110, 4'b1000, 4'b0001};
	int          num_errors = 0, total_checks = 0, n_txi = 0, n_rxi = 0, lows = 0, ln;
	int          tcnt = 0;
	longint      g;

	// 10 MHz clock
	always #50 aclk = ~aclk;

	ast_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .rxd(rxd), .timer3_output(tmr3), .txd(txd),
		.tx_start_interrupt(txi), .rx_done_interrupt(rxi));

	ast_remote u_rem (.aclk(aclk), .txd(txd), .rxd(rxd));

	// timer3 stand-in: one pulse in thirteen cycles keeps a bit at 208 cycles
	always @(posedge aclk) begin
		tcnt <= (tcnt == 12) ? 0 : tcnt + 1;
		tmr3 <= (tcnt == 12);
	end

	// interrupt pulses last one cycle, so count them edge by edge
	always @(posedge aclk) begin
		if (txi === 1'b1) n_txi++;
		if (rxi === 1'b1) n_rxi++;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
		total_checks++;
		if (e !== got) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, got);
		end
	endtask : chk

	// address and data offered together, each released once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	// watchdog: the whole sequence needs roughly 38k cycles
	initial begin
		repeat (80000) @(posedge aclk);
		num_errors++;
		wrap_up();
	end

	// main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		wr(4'h0, 32'h80);
		wr(4'h8, 32'h5a); // no status read yet, so this write must be dropped
		repeat (300) begin
			@(posedge aclk);
			lows += (txd !== 1'b1);
		end
		chk("txd idle", 0, lows);
		chk("tx irq", 0, n_txi);
		rd(4'h4);
		chk("reset status", 32'h0c, v);
		wr(4'hc, 32'h0);
		chk("unmapped wr", 2, r);
		wr(4'h4, 32'h0);
		chk("status wr", 2, r);
		rd(4'hc);
		chk("unmapped rd", 2, r);
		// two back-to-back bytes per format; second written while the first shifts
		for (int k = 0; k < 3; k++) begin
			wr(4'h0, cfg[k]);
			u_rem.par_on = cfg[k][3];
			u_rem.even = cfg[k][4];
			seed = lfsr(seed);
			d0 = seed[7:0];
			seed = lfsr(seed);
			d1 = seed[7:0];
			rd(4'h4);
			wr(4'h8, d0);
			rd(4'h4);
			chk("status shifting", 32'h04, v);
			wr(4'h8, d1);
			rd(4'h4);
			chk("status pending", 32'h00, v);
			do rd(4'h4); while (v[3] !== 1'b1);
			chk("status end", 32'h0c, v);
			chk("tx irq", 2 * (k + 1), n_txi);
			chk("frames", 2, u_rem.byte_q.size());
			chk("tx byte0", d0, u_rem.byte_q.pop_front());
			chk("tx byte1", d1, u_rem.byte_q.pop_front());
			chk("tx par0", cfg[k][3] & (cfg[k][4] ? ^d0 : ~^d0), u_rem.par_q.pop_front());
			chk("tx par1", cfg[k][3] & (cfg[k][4] ? ^d1 : ~^d1), u_rem.par_q.pop_front());
			ln = 10 + cfg[k][3] + cfg[k][5];
			g = u_rem.t_q.pop_front();
			g = (u_rem.t_q.pop_front() - g) / 100 - ln * 208;
			// load is not tick aligned, so the first start bit may lose up to one tick
			chk("frame gap", 1, g >= -12 && g <= 0);
		end
		// receive cases: plain, bad even parity, good odd parity, bad stop
		for (int k = 0; k < 4; k++) begin
			wr(4'h0, {24'h0, 1'b0, 1'b1, 1'b0, rxc[k][2], rxc[k][3], 3'b000});
			u_rem.par_on = rxc[k][3];
			u_rem.even = rxc[k][2];
			seed = lfsr(seed);
			u_rem.send(seed[7:0], rxc[k][1], rxc[k][0]);
			chk("rx irq", k + 1, n_rxi);
			rd(4'h4);
			chk("rx status", {rxc[k][3] & rxc[k][1], rxc[k][0], 6'b011100}, v);
			rd(4'h8);
			chk("rx data", seed[7:0], v);
			rd(4'h4);
			chk("rx cleared", 32'h0c, v);
		end
		// rate code 6 on the timer pulse; receive enable dropped mid-frame still lands
		wr(4'h0, 32'h46);
		u_rem.par_on = 1'b0;
		seed = lfsr(seed);
		fork
			u_rem.send(seed[7:0], 1'b0, 1'b0);
			begin
				repeat (600) @(posedge aclk);
				wr(4'h0, 32'h06);
			end
		join
		chk("rx irq", 5, n_rxi);
		rd(4'h4);
		chk("rx status", 32'h1c, v);
		rd(4'h8);
		chk("rx data", seed[7:0], v);
		u_rem.send(~seed[7:0], 1'b0, 1'b0);
		chk("rx irq", 5, n_rxi);
		// overrun raised between the status read and the data read
		wr(4'h0, 32'h40);
		u_rem.par_on = 1'b0;
		seed = lfsr(seed);
		u_rem.send(seed[7:0], 1'b0, 1'b0);
		rd(4'h4);
		u_rem.send(~seed[7:0], 1'b0, 1'b0);
		rd(4'h8);
		chk("held byte", seed[7:0], v);
		rd(4'h4);
		chk("overrun kept", 32'h2c, v);
		u_rem.send(8'h3c, 1'b0, 1'b0);
		chk("rx irq", 6, n_rxi);
		rd(4'h8);
		chk("held byte", seed[7:0], v);
		rd(4'h4);
		chk("overrun clear", 32'h0c, v);
		wrap_up();
	end
endmodule : tb
